// ### core/pmc_cfg_port.sv
/*
  Configuration access port: decodes the dword, splits byte-lane writes,
  registers read data. Assumes single-cycle read and write strobes.
*/
`timescale 1ns/1ps
module pmc_cfg_port
  import pmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  pmc_reg_if.port bus
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pmc_port_st_t;

  pmc_port_st_t st_r;
  pmc_port_st_t st_nxt;
  logic hit;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign hit = pmc_hit(cfg_addr_i);
  // Lane 2 is read-only, so no strobe exists for it
  assign bus.wr_ps = cfg_wr_i & hit & cfg_be_i[PMC_LANE_PS];
  assign bus.wr_ctl = cfg_wr_i & hit & cfg_be_i[PMC_LANE_CTL];
  assign bus.wdata = cfg_wdata_i[15:0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = cfg_rd_i | cfg_wr_i;
    if (cfg_rd_i) begin
      // Unmapped dwords read as zero
      st_nxt.rdata = hit ? bus.rword : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_o = st_r.rdata;
  assign cfg_ack_o = st_r.ack;

endmodule : pmc_cfg_port

// ### core/pmc_csr_top.sv
/*
  Power-management control/status and bridge extension registers of the
  card-bus function, reached through configuration space.
  Assumes rst_n_i is the global reset, all inputs synchronous to ref_clk_i,
  and one config access at a time.
*/
// Functional notes
// RULE1 - The wake flag is set on every wake condition whether or not wake is permitted.
// RULE2 - Writing 1 to the wake flag clears it and drops our wake request; 0 does nothing.
// RULE3 - The data-scale and data-select fields always read zero.
// RULE4 - The wake permit bit gates the wake request; cleared, no request is made.
// RULE5 - The wake permit bit is cleared only by global reset, never by bus reset.
// RULE6 - Bus reset clears the wake flag only while wake is not permitted.
// RULE7 - Reserved bits 7..2 of the control/status and 5..0 of the extension read zero.
// RULE8 - The power-state field reads the present state and a write moves to a new one.
// RULE9 - The control/status register survives the internal reset on leaving D3hot.
// RULE10 - Leaving D3hot for D0 resets the rest of the function except wake context.
// RULE11 - The secondary power/clock control enable reads as one.
// RULE12 - The D3hot action bit reads one, so D3hot stops the secondary clock.
// RULE13 - Writes to read-only fields are ignored and change nothing.
`timescale 1ns/1ps
module pmc_csr_top
  import pmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pci_bus_reset_n_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic wake_cond_i,
  output logic wake_req_o,
  output logic [1:0] power_state_o,
  output logic func_reset_o,
  output logic sec_clk_stop_o
);

  typedef struct packed {
    pmc_pstate_t pstate;
    logic [2:0] rst_cnt;
  } pmc_top_st_t;

  pmc_top_st_t st_r;
  pmc_top_st_t st_nxt;
  pmc_pstate_t wr_val;
  logic leave_d3;
  logic [7:0] bse_word;
  logic [15:0] csr_word;
  logic rd_hit;

  pmc_reg_if bus ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  pmc_cfg_port u_port (
    .ref_clk_i (ref_clk_i),
    .rst_n_i (rst_n_i),
    .cfg_rd_i (cfg_rd_i),
    .cfg_wr_i (cfg_wr_i),
    .cfg_addr_i (cfg_addr_i),
    .cfg_be_i (cfg_be_i),
    .cfg_wdata_i (cfg_wdata_i),
    .cfg_rdata_o (cfg_rdata_o),
    .cfg_ack_o (cfg_ack_o),
    .bus (bus.port)
  );

  pmc_wake_ctl u_wake (
    .ref_clk_i (ref_clk_i),
    .rst_n_i (rst_n_i),
    .pci_bus_reset_n_i (pci_bus_reset_n_i),
    .wake_cond_i (wake_cond_i),
    .bus (bus.wake)
  );

  // ----------------------------------------------------------------
  // Read word
  // ----------------------------------------------------------------
  // Extension byte is a constant; writes to lane 2 have no strobe
  assign bse_word = PMC_BSE_RST;  // see RULE11 see RULE12 see RULE13
  // Scale, select and reserved bits come from the zero reset pattern
  assign csr_word = pmc_pack_csr(bus.flag, bus.permit, st_r.pstate);  // see RULE3 see RULE7
  // Upper byte is the data register, which reports nothing
  assign bus.rword = {8'h00, bse_word, csr_word};

  // ----------------------------------------------------------------
  // Power state and internal reset
  // ----------------------------------------------------------------
  assign wr_val = pmc_pstate_t'(bus.wdata[PMC_PS_LSB +: 2]);
  assign leave_d3 = bus.wr_ps && (st_r.pstate == PMC_D3HOT) && (wr_val == PMC_D0);
  assign rd_hit = cfg_rd_i && pmc_hit(cfg_addr_i);

  always_comb begin
    st_nxt = st_r;
    if (st_r.rst_cnt != 3'h0) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 3'h1;
    end
    if (!pci_bus_reset_n_i) begin
      // Bus reset already resets the function; no extra pulse
      st_nxt.pstate = PMC_D0;
      st_nxt.rst_cnt = 3'h0;
    end else if (bus.wr_ps) begin
      case (wr_val)
        PMC_D0: st_nxt.pstate = PMC_D0;  // see RULE8
        PMC_D1: st_nxt.pstate = PMC_D1;
        PMC_D2: st_nxt.pstate = PMC_D2;
        PMC_D3HOT: st_nxt.pstate = PMC_D3HOT;
        default: st_nxt.pstate = st_r.pstate;
      endcase
      if (leave_d3) begin
        st_nxt.rst_cnt = PMC_INT_RST_CYC;  // see RULE10
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '{pstate: PMC_D0, rst_cnt: 3'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign power_state_o = st_r.pstate;
  // The internal reset pulse does not reach this register pair
  assign func_reset_o = (st_r.rst_cnt != 3'h0);  // see RULE9 see RULE10
  assign wake_req_o = bus.req;  // see RULE2
  // B2 chosen: D3hot stops the secondary clock, power stays on
  assign sec_clk_stop_o = (st_r.pstate == PMC_D3HOT) && bse_word[PMC_BSE_EN_BIT]
                          && bse_word[PMC_BSE_B2_BIT];  // see RULE12

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_flag_sets;
    (wake_cond_i && pci_bus_reset_n_i) |=> bus.flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets)  // see RULE1
    else $error("wake flag not set by wake condition");

  property p_flag_sets_unpermitted;
    (wake_cond_i && !bus.permit && !bus.wr_ctl && pci_bus_reset_n_i)
      |=> bus.flag && !wake_req_o;
  endproperty
  a_flag_sets_unpermitted: assert property (p_flag_sets_unpermitted)  // see RULE1
    else $error("flag or request wrong with wake not permitted");

  property p_flag_clear_one;
    (bus.wr_ctl && bus.wdata[PMC_FLAG_BIT] && !wake_cond_i)
      |=> !bus.flag && !wake_req_o;
  endproperty
  a_flag_clear_one: assert property (p_flag_clear_one)  // see RULE2
    else $error("write of one did not clear flag and request");

  property p_flag_write_zero;
    (bus.wr_ctl && !bus.wdata[PMC_FLAG_BIT] && bus.flag && pci_bus_reset_n_i)
      |=> bus.flag;
  endproperty
  a_flag_write_zero: assert property (p_flag_write_zero)  // see RULE2
    else $error("write of zero changed the wake flag");

  property p_read_zero_fields;
    (cfg_ack_o && $past(rd_hit))
      |-> cfg_rdata_o[14:9] == 6'h00;
  endproperty
  a_read_zero_fields: assert property (p_read_zero_fields)  // see RULE3
    else $error("data scale or select not zero");

  property p_no_req_unpermitted;
    !bus.permit |-> !wake_req_o;
  endproperty
  a_no_req_unpermitted: assert property (p_no_req_unpermitted)  // see RULE4
    else $error("wake request without permit");

  property p_req_when_permitted;
    (wake_cond_i && bus.permit && !bus.wr_ctl && pci_bus_reset_n_i)
      |=> wake_req_o [*2];
  endproperty
  a_req_when_permitted: assert property (p_req_when_permitted)  // see RULE4
    else $error("permitted wake did not raise the request");

  property p_bus_reset_flag;
    (!pci_bus_reset_n_i && !bus.permit) |=> !bus.flag;
  endproperty
  a_bus_reset_flag: assert property (p_bus_reset_flag)  // see RULE6
    else $error("bus reset left flag set with wake not permitted");

  property p_bus_reset_keeps_flag;
    (!pci_bus_reset_n_i && bus.permit && bus.flag && !bus.wr_ctl) |=> bus.flag;
  endproperty
  a_bus_reset_keeps_flag: assert property (p_bus_reset_keeps_flag)  // see RULE6
    else $error("bus reset cleared flag while wake permitted");

  property p_read_reserved;
    (cfg_ack_o && $past(rd_hit))
      |-> cfg_rdata_o[7:2] == 6'h00 && cfg_rdata_o[21:16] == 6'h00;
  endproperty
  a_read_reserved: assert property (p_read_reserved)  // see RULE7
    else $error("reserved bits not zero");

  property p_ps_write;
    (bus.wr_ps && pci_bus_reset_n_i) |=> power_state_o == $past(wr_val);
  endproperty
  a_ps_write: assert property (p_ps_write)  // see RULE8
    else $error("power state not taken from write");

  property p_ps_read;
    (cfg_rd_i && pmc_hit(cfg_addr_i)) |=> cfg_ack_o && cfg_rdata_o[1:0] == $past(power_state_o);
  endproperty
  a_ps_read: assert property (p_ps_read)  // see RULE8
    else $error("power state read back wrong");

  property p_csr_survives;
    (leave_d3 && !bus.wr_ctl && pci_bus_reset_n_i)
      |=> $stable(bus.permit) && (bus.flag || !$past(bus.flag));
  endproperty
  a_csr_survives: assert property (p_csr_survives)  // see RULE9
    else $error("control/status lost on leaving D3hot");

  property p_int_reset_pulse;
    (leave_d3 && pci_bus_reset_n_i) |=> func_reset_o [*4] ##1 !func_reset_o;
  endproperty
  a_int_reset_pulse: assert property (p_int_reset_pulse)  // see RULE10
    else $error("internal reset pulse length wrong");

  property p_no_spurious_reset;
    (!func_reset_o && !leave_d3) |=> !func_reset_o;
  endproperty
  a_no_spurious_reset: assert property (p_no_spurious_reset)  // see RULE10
    else $error("internal reset without D3hot exit");

  property p_read_ext;
    (cfg_ack_o && $past(rd_hit))
      |-> cfg_rdata_o[23] && cfg_rdata_o[22];
  endproperty
  a_read_ext: assert property (p_read_ext)  // see RULE11
    else $error("extension control bits not one");

  property p_d3_clock_stop;
    sec_clk_stop_o == (power_state_o == PMC_D3HOT);
  endproperty
  a_d3_clock_stop: assert property (p_d3_clock_stop)  // see RULE12
    else $error("secondary clock stop does not follow D3hot");

  property p_ro_write_ignored;
    (cfg_wr_i && pmc_hit(cfg_addr_i) && !cfg_be_i[PMC_LANE_PS] && !cfg_be_i[PMC_LANE_CTL]
      && pci_bus_reset_n_i)
      |=> $stable(power_state_o) && $stable(bus.permit) && !func_reset_o;
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)  // see RULE13
    else $error("write to read-only lane had an effect");

  property p_read_live_bits;
    (cfg_ack_o && $past(rd_hit))
      |-> cfg_rdata_o[PMC_FLAG_BIT] == $past(bus.flag)
          && cfg_rdata_o[PMC_PERMIT_BIT] == $past(bus.permit);
  endproperty
  a_read_live_bits: assert property (p_read_live_bits)  // see RULE1
    else $error("flag or permit read back wrong");

  property p_read_data_byte;
    (cfg_ack_o && $past(rd_hit)) |-> cfg_rdata_o[31:24] == 8'h00;
  endproperty
  a_read_data_byte: assert property (p_read_data_byte)  // see RULE3
    else $error("data byte not zero");

  property p_flag_no_spurious;
    (!bus.flag && !wake_cond_i) |=> !bus.flag;
  endproperty
  a_flag_no_spurious: assert property (p_flag_no_spurious)  // see RULE1
    else $error("wake flag set without wake condition");

  property p_req_no_spurious;
    (!wake_req_o && !wake_cond_i) |=> !wake_req_o;
  endproperty
  a_req_no_spurious: assert property (p_req_no_spurious)  // see RULE4
    else $error("wake request without wake condition");

  property p_permit_set;
    (bus.wr_ctl && bus.wdata[PMC_PERMIT_BIT]) |=> bus.permit;
  endproperty
  a_permit_set: assert property (p_permit_set)  // see RULE4
    else $error("wake permit not set by write");

  property p_permit_clear;
    (bus.wr_ctl && !bus.wdata[PMC_PERMIT_BIT]) |=> !bus.permit && !wake_req_o;
  endproperty
  a_permit_clear: assert property (p_permit_clear)  // see RULE4
    else $error("wake permit clear left permit or request up");

  property p_bus_reset_state;
    !pci_bus_reset_n_i |=> power_state_o == PMC_D0 && !func_reset_o;
  endproperty
  a_bus_reset_state: assert property (p_bus_reset_state)  // see RULE8
    else $error("bus reset did not return to D0");

  property p_ps_hold;
    (!bus.wr_ps && pci_bus_reset_n_i) |=> $stable(power_state_o);
  endproperty
  a_ps_hold: assert property (p_ps_hold)  // see RULE8
    else $error("power state changed without write");

endmodule : pmc_csr_top

// ### core/pmc_pkg.sv
/*
  Constants, types and helpers for the power-management register pair.
  Assumes byte offsets into configuration space, dword-wide data.
*/
package pmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PMC_CSR_OFS = 8'hA4;
  localparam logic [7:0] PMC_BSE_OFS = 8'hA6;
  localparam logic [5:0] PMC_DW_IDX = PMC_CSR_OFS[7:2];
  localparam int PMC_LANE_PS = 0;
  localparam int PMC_LANE_CTL = 1;
  localparam int PMC_LANE_BSE = int'(PMC_BSE_OFS[1:0]);

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PMC_FLAG_BIT = 15;
  localparam int PMC_PERMIT_BIT = 8;
  localparam int PMC_PS_LSB = 0;
  localparam logic [15:0] PMC_CSR_RST = 16'h0000;
  localparam logic [7:0] PMC_BSE_RST = 8'hC0;
  localparam int PMC_BSE_EN_BIT = 7;
  localparam int PMC_BSE_B2_BIT = 6;
  localparam logic [2:0] PMC_INT_RST_CYC = 3'h4;

  typedef enum logic [1:0] {
    PMC_D0 = 2'b00,
    PMC_D1 = 2'b01,
    PMC_D2 = 2'b10,
    PMC_D3HOT = 2'b11
  } pmc_pstate_t;

  function automatic logic pmc_hit(input logic [7:0] addr);
    return addr[7:2] == PMC_DW_IDX;
  endfunction : pmc_hit

  function automatic logic [15:0] pmc_pack_csr(input logic flag, input logic permit,
                                               input logic [1:0] ps);
    logic [15:0] v;
    v = PMC_CSR_RST;
    v[PMC_FLAG_BIT] = flag;
    v[PMC_PERMIT_BIT] = permit;
    v[PMC_PS_LSB +: 2] = ps;
    return v;
  endfunction : pmc_pack_csr

endpackage : pmc_pkg

// ### core/pmc_reg_if.sv
/*
  Carrier between the config port, the wake logic and the top.
  Assumes all parties run on the same clock.
*/
`timescale 1ns/1ps
interface pmc_reg_if;
  logic wr_ps;
  logic wr_ctl;
  logic [15:0] wdata;
  logic [31:0] rword;
  logic flag;
  logic permit;
  logic req;

  modport port (output wr_ps, output wr_ctl, output wdata, input rword);
  modport core (input wr_ps, input wr_ctl, input wdata, input flag, input permit,
                input req, output rword);
  modport wake (input wr_ctl, input wdata, output flag, output permit, output req);
endinterface : pmc_reg_if

// ### core/pmc_wake_ctl.sv
/*
  Wake event flag, wake permit and wake request.
  Assumes global reset on rst_n_i and a synchronous bus reset input.
*/
`timescale 1ns/1ps
module pmc_wake_ctl
  import pmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pci_bus_reset_n_i,
  input wire logic wake_cond_i,
  pmc_reg_if.wake bus
);

  typedef struct packed {
    logic flag;
    logic permit;
    logic req;
  } pmc_wake_st_t;

  pmc_wake_st_t st_r;
  pmc_wake_st_t st_nxt;
  logic clr;

  assign clr = bus.wr_ctl & bus.wdata[PMC_FLAG_BIT];

  always_comb begin
    st_nxt = st_r;
    if (bus.wr_ctl) begin
      st_nxt.permit = bus.wdata[PMC_PERMIT_BIT];
    end
    // Event beats a same-cycle clear
    st_nxt.flag = wake_cond_i | (st_r.flag & ~clr);  // see RULE1 see RULE2
    st_nxt.req = st_nxt.permit & (wake_cond_i | (st_r.req & ~clr));  // see RULE4
    // Flag is wake context only while the permit is set
    if (!pci_bus_reset_n_i && !st_r.permit) begin
      st_nxt.flag = 1'b0;  // see RULE6
      st_nxt.req = 1'b0;
    end
  end

  // Permit has no bus-reset term at all
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;  // see RULE5
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.flag = st_r.flag;
  assign bus.permit = st_r.permit;
  assign bus.req = st_r.req;

  property p_permit_keeps;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (!pci_bus_reset_n_i && !bus.wr_ctl) |=> $stable(bus.permit);
  endproperty
  a_permit_keeps: assert property (p_permit_keeps)  // see RULE5
    else $error("wake permit changed under bus reset");

endmodule : pmc_wake_ctl

// ### tb/pci_power_mgmt_csr_tb.sv
/*
  Self-checking bench for the power-management register pair.
  Assumes the design answers every access one cycle after it is taken.
*/
`timescale 1ns/1ps
module pci_power_mgmt_csr_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic bus_rst_n = 1'b1;
  logic wake_cond = 1'b0;
  logic cfg_rd, cfg_wr, cfg_ack, wake_req, func_rst, clk_stop;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [1:0] pstate;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int m_flag, m_permit, m_req, m_st;

  always #25 ref_clk_i = ~ref_clk_i;

  pmc_host_model i_pmc_host_model (.ref_clk_i(ref_clk_i), .cfg_rd_o(cfg_rd),
    .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata),
    .cfg_rdata_i(cfg_rdata), .cfg_ack_i(cfg_ack));

  pmc_csr_top i_pmc_csr_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .pci_bus_reset_n_i(bus_rst_n), .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr),
    .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack), .wake_cond_i(wake_cond),
    .wake_req_o(wake_req), .power_state_o(pstate), .func_reset_o(func_rst),
    .sec_clk_stop_o(clk_stop));

  // ----------------------------------------------------------------
  // Checking and reference model
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic check_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // Upper half is the fixed extension byte and an all-zero data byte
  function automatic logic [31:0] exp_word();
    return {16'h00C0, 1'(m_flag), 6'h00, 1'(m_permit), 6'h00, 2'(m_st)};
  endfunction : exp_word

  // Read the pair and compare every result the design shows except func_reset_o
  task automatic reg_rd();
    logic [31:0] d;
    logic a;
    i_pmc_host_model.access(1'b0, 8'hA4, 4'h0, 32'h0, d, a);
    check_bit("ack", 1'b1, a);
    check_word("csr", exp_word(), d);
    check_bit("wake_req", 1'(m_req), wake_req);
    check_word("power_state", 32'(m_st), {30'h0, pstate});
    check_bit("clk_stop", m_st == 3, clk_stop);
  endtask : reg_rd

  task automatic reg_wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    logic a;
    i_pmc_host_model.access(1'b1, addr, be, d, q, a);
    check_bit("ack", 1'b1, a);
    if (addr[7:2] == 6'h29 && be[0]) begin
      m_st = d[1:0];
    end
    if (addr[7:2] == 6'h29 && be[1]) begin
      m_permit = d[8];
      if (d[15]) begin
        m_flag = 0;
        m_req = 0;
      end
    end
    m_req = m_req & m_permit;
  endtask : reg_wr

  task automatic wake_event();
    @(negedge ref_clk_i);
    wake_cond = 1'b1;
    @(negedge ref_clk_i);
    wake_cond = 1'b0;
    m_flag = 1;
    m_req = m_permit;
  endtask : wake_event

  task automatic bus_reset();
    @(negedge ref_clk_i);
    bus_rst_n = 1'b0;
    @(negedge ref_clk_i);
    bus_rst_n = 1'b1;
    m_st = 0;
    if (m_permit == 0) begin
      m_flag = 0;
      m_req = 0;
    end
  endtask : bus_reset

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      $display("mismatch timeout expected done seen hang");
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [31:0] q;
    logic a;
    m_flag = 0;
    m_permit = 0;
    m_req = 0;
    m_st = 0;
    void'($urandom(32'hC6CD));
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    reg_rd();
    $display("test reset values done");
    reg_wr(8'hA4, 4'hF, 32'hFFFF_7FFF);
    reg_rd();
    $display("test read-only fields done");
    reg_wr(8'hA4, 4'h1, 32'h0000_0100);
    n = 0;
    repeat (6) begin
      n += int'(func_rst === 1'b1);
      @(negedge ref_clk_i);
    end
    check_word("func_reset_len", 32'd4, 32'(n));
    reg_rd();
    $display("test leaving d3hot done");
    for (int s = 0; s < 4; s++) begin
      reg_wr(8'hA4, 4'hF, ($urandom() & 32'hFFFF_7EFC) | 32'h100 | s);
      reg_rd();
    end
    $display("test state encodings done");
    wake_event();
    reg_rd();
    reg_wr(8'hA4, 4'h2, 32'h0000_0100);
    reg_rd();
    bus_reset();
    reg_rd();
    reg_wr(8'hA4, 4'h2, 32'h0000_8100);
    reg_rd();
    $display("test wake with permit done");
    reg_wr(8'hA4, 4'h2, 32'h0000_0000);
    wake_event();
    reg_rd();
    bus_reset();
    reg_rd();
    $display("test wake without permit done");
    i_pmc_host_model.access(1'b0, 8'h40, 4'h0, 32'h0, q, a);
    check_word("unmapped", 32'h0, q);
    reg_wr(8'h40, 4'hF, 32'hFFFF_FFFF);
    reg_wr(8'hA6, 4'hC, 32'hFFFF_FFFF);
    reg_rd();
    $display("test unmapped done");
    reg_wr(8'hA4, 4'h3, 32'h0000_0102);
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    m_permit = 0;
    m_st = 0;
    m_flag = 0;
    m_req = 0;
    reg_rd();
    $display("test global reset done");
    results();
  end
endmodule : pci_power_mgmt_csr_tb

// ### tb/pmc_host_model.sv
/*
  Configuration-space master standing in for the host and its software.
  Assumes tasks are called from one bench process, clock from the bench.
*/
`timescale 1ns/1ps
module pmc_host_model (
  input wire logic ref_clk_i,
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_ack_i
);
  initial begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h0;
  end

  // One access, launched and released on falling edges
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] data, output logic [31:0] rdata,
                        output logic ack);
    @(negedge ref_clk_i);
    cfg_rd_o = ~wr;
    cfg_wr_o = wr;
    cfg_addr_o = addr;
    cfg_be_o = be;
    cfg_wdata_o = data;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    // Released data must not look valid
    cfg_wdata_o = ~data;
    ack = cfg_ack_i;
    rdata = cfg_rdata_i;
  endtask : access
endmodule : pmc_host_model
